// [testbench/rpa_chk.sv]
// checker: bus handshake and status relations of the applier
`timescale 1ns/1ns
module rpa_chk (
	// clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_nrst,
	// inputs watched
	input  wire logic                        i_sel_valid,
	input  wire logic                        i_bus_grant,
	input  wire logic [rpa_pkg::BUS_W-1:0]   i_rc_readdata,
	input  wire logic                        i_rc_waitrequest,
	// outputs watched
	input  wire logic [rpa_pkg::ADR_W-1:0]   o_rc_address,
	input  wire logic                        o_rc_read,
	input  wire logic                        o_rc_write,
	input  wire logic [rpa_pkg::BUS_W-1:0]   o_rc_writedata,
	input  wire logic                        o_busy,
	input  wire logic                        o_done,
	input  wire logic [rpa_pkg::PROF_W-1:0]  o_active_prof
);
	// all relations sampled on the core clock, off in reset
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	property p_rd_hold;
		o_rc_read && i_rc_waitrequest |=> o_rc_read && $stable(o_rc_address);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read moved while stalled");
	property p_rd_then_wr;
		o_rc_read && !i_rc_waitrequest
			|=> o_rc_write && !o_rc_read && $stable(o_rc_address);
	endproperty
	a_rd_then_wr: assert property (p_rd_then_wr)
		else $error("read not followed by write");
	property p_wr_hold;
		o_rc_write && i_rc_waitrequest
			|=> o_rc_write && $stable({o_rc_address, o_rc_writedata});
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write moved while stalled");
	property p_wr_keep;
		$rose(o_rc_write) |-> (o_rc_writedata & 32'hFFFFFF00) ==
			($past(i_rc_readdata) & 32'hFFFFFF00);
	endproperty
	a_wr_keep: assert property (p_wr_keep)
		else $error("unmasked bytes altered");
	property p_grant;
		$rose(o_rc_read) |-> $past(i_bus_grant);
	endproperty
	a_grant: assert property (p_grant)
		else $error("access without grant");
	property p_idle_quiet;
		!o_busy |-> !o_rc_read && !o_rc_write;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("access while idle");
	property p_take;
		!o_busy && i_sel_valid |=> o_busy;
	endproperty
	a_take: assert property (p_take)
		else $error("selection not taken");
	property p_busy_end;
		$fell(o_busy) |-> o_done;
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("busy ended without done");
	property p_prof_move;
		$changed(o_active_prof) |-> o_done;
	endproperty
	a_prof_move: assert property (p_prof_move)
		else $error("profile changed outside done");
endmodule

// attach to every applier instance
bind rpa_applier rpa_chk i_chk (.i_core_clk, .i_nrst, .i_sel_valid,
	.i_bus_grant, .i_rc_readdata, .i_rc_waitrequest, .o_rc_address,
	.o_rc_read, .o_rc_write, .o_rc_writedata, .o_busy, .o_done,
	.o_active_prof);

// [testbench/rpa_slave.sv]
// model: reconfiguration slave with stalled reads and a register array
`timescale 1ns/1ns
module rpa_slave (
	// clock
	input  wire logic        i_core_clk,
	// bus from the master
	input  wire logic [10:0] i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_dly,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest
);
	logic [31:0] mem [2048];
	logic [3:0]  cnt_q;
	logic [31:0] junk_q;

	// registers start from a per-address pattern
	initial
	begin
		junk_q = 32'h0;
		for (int i = 0; i < 2048; i++)
			mem[i] = {8'h5A, i[7:0], 5'h00, i[10:0]};
	end
	// stall count reloads between transfers and as a read ends, so the
	// write that follows is stalled as well; counts down inside one
	always @(posedge i_core_clk)
	begin
		junk_q <= junk_q + 32'h9E3779B9;
		if (!(i_read || i_write) || (i_read && cnt_q == 4'h0))
			cnt_q <= i_dly;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
		if (i_write && cnt_q == 4'h0)
			mem[i_address] <= i_writedata;
	end
	// data is only valid on the releasing cycle of a read
	assign o_waitrequest = !(i_read || i_write) || cnt_q != 4'h0;
	assign o_readdata = (i_read && cnt_q == 4'h0) ? mem[i_address] : junk_q;
endmodule

// [testbench/tb.sv]
// testbench: profile switching against a slave model, self-checking
`timescale 1ns/1ns
module tb;
	logic        clk, nrst, ld_e, ld_c, sel, fpm, den, gnt;
	logic        rd, wr, wrq, breq, busy, done, err;
	logic [2:0]  ld_p, sel_p, act, cur;
	logic [3:0]  ld_i, dly;
	logic [26:0] ld_d;
	logic [4:0]  ld_n;
	logic [1:0]  ld_dp;
	logic [10:0] adr;
	logic [31:0] wd, rdat, seed;
	logic [26:0] ent [8][16];
	logic [4:0]  cnt [8];
	logic [1:0]  dp [8];
	logic [31:0] mem [2048];
	logic [44:0] q [$];
	int          n_errors, checks, cyc;

	// device and far side
	rpa_applier i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_load_ent(ld_e),
		.i_load_cnt(ld_c), .i_load_prof(ld_p), .i_load_idx(ld_i),
		.i_load_data(ld_d), .i_load_count(ld_n), .i_load_dpath(ld_dp),
		.i_sel_valid(sel), .i_sel_prof(sel_p), .i_fractional_pll_core_mode(fpm),
		.i_dpath_reconfig_en(den), .i_bus_grant(gnt), .o_bus_req(breq),
		.o_rc_address(adr), .o_rc_read(rd), .o_rc_write(wr),
		.o_rc_writedata(wd), .i_rc_readdata(rdat),
		.i_rc_waitrequest(wrq), .o_busy(busy), .o_done(done),
		.o_error(err), .o_active_prof(act));
	rpa_slave i_slv (.i_core_clk(clk), .i_address(adr), .i_read(rd),
		.i_write(wr), .i_writedata(wd), .i_dly(dly),
		.o_readdata(rdat), .o_waitrequest(wrq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one counted comparison
	task automatic chk(input string nm, input logic [44:0] s, e);
		checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		$display("mismatches %0d comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// load a whole profile, entries then count and datapath code
	task automatic mk(input logic [2:0] p);
		ld_p = p;
		for (int i = 0; i < cnt[p]; i++)
		begin
			ld_e = 1;
			ld_i = 4'(i);
			ld_d = ent[p][i];
			@(negedge clk);
		end
		ld_e = 0;
		ld_c = 1;
		ld_n = cnt[p];
		ld_dp = dp[p];
		@(negedge clk);
		ld_c = 0;
	endtask
	// switch; o[0] adds a refused select and load, o[1] withholds grant
	task automatic sw(input logic [2:0] p, input logic [1:0] o);
		logic        bad;
		logic [26:0] e;
		logic [31:0] v;
		bad = fpm || cnt[p] !== cnt[cur] || (dp[p] !== dp[cur] && !den);
		for (int k = 0; k < cnt[p] && !bad; k++)
		begin
			e = ent[p][k];
			if (e[26:16] !== ent[cur][k][26:16])
				bad = 1;
			else if (e !== ent[cur][k])
			begin
				v = mem[e[26:16]];
				v[7:0] = (v[7:0] & ~e[15:8]) | (e[7:0] & e[15:8]);
				mem[e[26:16]] = v;
				q.push_back({2'h0, e[26:16], v});
			end
		end
		q.push_back({1'b1, 40'h0, bad, bad ? cur : p});
		if (!bad)
			cur = p;
		seed = lfsr(seed);
		dly = {1'b0, seed[2:0]};
		gnt = !o[1];
		sel = 1;
		sel_p = p;
		@(negedge clk);
		sel = 0;
		chk("busy", 45'({busy, breq}), 45'h3);
		if (o[0])
		begin
			@(negedge clk);
			{sel, ld_e, sel_p, ld_p, ld_i, ld_d} = {2'h3, ~p, p, 4'h0, ~e};
			@(negedge clk);
			{sel, ld_e} = 2'h0;
		end
		if (o[1])
		begin
			repeat (20) @(negedge clk);
			gnt = 1;
		end
		while (done !== 1'b1)
			@(negedge clk);
	endtask

	// clock
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// each result from the design meets the oldest note
	always @(negedge clk)
		if (nrst && (done || (wr && !wrq)))
		begin
			if (q.size() == 0)
				chk("unexpected", 45'h1, 45'h0);
			else if (done)
				chk("done", {1'b1, 40'h0, err, act}, q.pop_front());
			else
				chk("write", {2'h0, adr, wd}, q.pop_front());
		end
	// cut a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			tally_and_finish;
		end
	end
	// main sequence
	initial
	begin
		{nrst, ld_e, ld_c, sel, fpm, den, ld_p, ld_i, ld_d} = 0;
		{ld_n, ld_dp, sel_p, dly, cur} = 0;
		gnt = 1;
		seed = 32'h71C0;
		for (int i = 0; i < 2048; i++)
			mem[i] = {8'h5A, i[7:0], 5'h00, i[10:0]};
		for (int p = 0; p < 8; p++)
			for (int i = 0; i < 16; i++)
				ent[p][i] = 27'h0;
		dp = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h3};
		repeat (20) @(negedge clk);
		chk("reset", 45'({busy, done, err, act, rd, wr, breq}), 45'h0);
		nrst = 1;
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			ent[0][i] = seed[26:0];
		end
		ent[1] = ent[0];
		for (int i = 1; i < 5; i += i)
			ent[1][i][15:0] = ent[1][i][15:0] ^ (seed[15:0] | 16'h0001);
		ent[2] = ent[1];
		ent[3] = ent[1];
		ent[4] = ent[1];
		ent[3][3][7:0] = ent[3][3][7:0] ^ 8'h5A;
		ent[3][5][26:16] = ent[3][5][26:16] ^ 11'h001;
		ent[4][0][15:8] = ~ent[4][0][15:8];
		cnt = '{5'h06, 5'h06, 5'h05, 5'h06, 5'h06, 5'h00, 5'h00, 5'h00};
		for (int p = 0; p < 8; p++)
			mk(3'(p));
		sw(3'h0, 2'h0);
		sw(3'h1, 2'h3);
		sw(3'h2, 2'h0);
		sw(3'h3, 2'h0);
		sw(3'h4, 2'h0);
		den = 1;
		sw(3'h4, 2'h1);
		fpm = 1;
		sw(3'h0, 2'h0);
		fpm = 0;
		sw(3'h0, 2'h0);
		for (int r = 0; r < 12; r++)
		begin
			seed = lfsr(seed);
			sw(seed[6:4], {1'b0, seed[7]});
		end
		repeat (10) @(negedge clk);
		chk("queue", 45'(q.size()), 45'h0);
		tally_and_finish;
	end
endmodule

// [verilog/rpa_applier.sv]
// module: profile switcher that writes differing entries to the slave
//
// Overview of operation
// - every stored entry is one 27-bit word
// - bits 26:16 hold the target register address
// - bits 15:8 mask, bits 7:0 feature values
// - fields sharing an address update under one mask
// - one entry format whatever the load source
// - never target a fractional_pll in core mode
// - bridge entries written through the same port
// - analog entries written like any other entry
// - target must use only ports base has
// - datapath switch needs datapath reconfiguration enabled
// - base and target entry sets must match
// - hold address and read until stall released
// - write presents address, strobe and data together
`timescale 1ns/1ns
module rpa_applier (
	// clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_nrst,
	// profile load port
	input  wire logic                          i_load_ent,
	input  wire logic                          i_load_cnt,
	input  wire logic [rpa_pkg::PROF_W-1:0]    i_load_prof,
	input  wire logic [rpa_pkg::IDX_W-1:0]     i_load_idx,
	input  wire logic [rpa_pkg::ENT_W-1:0]     i_load_data,
	input  wire logic [rpa_pkg::CNT_W-1:0]     i_load_count,
	input  wire logic [rpa_pkg::DP_W-1:0]      i_load_dpath,
	// profile selection
	input  wire logic                          i_sel_valid,
	input  wire logic [rpa_pkg::PROF_W-1:0]    i_sel_prof,
	// instance options
	input  wire logic                          i_fractional_pll_core_mode,
	input  wire logic                          i_dpath_reconfig_en,
	// config bus arbitration
	input  wire logic                          i_bus_grant,
	output logic                               o_bus_req,
	// reconfiguration bus
	output logic      [rpa_pkg::ADR_W-1:0]     o_rc_address,
	output logic                               o_rc_read,
	output logic                               o_rc_write,
	output logic      [rpa_pkg::BUS_W-1:0]     o_rc_writedata,
	input  wire logic [rpa_pkg::BUS_W-1:0]     i_rc_readdata,
	input  wire logic                          i_rc_waitrequest,
	// status
	output logic                               o_busy,
	output logic                               o_done,
	output logic                               o_error,
	output logic      [rpa_pkg::PROF_W-1:0]    o_active_prof
);
	typedef struct packed {
		rpa_pkg::rpa_main_e               st;
		logic [rpa_pkg::PROF_W-1:0]       cur;
		logic [rpa_pkg::PROF_W-1:0]       tgt;
		logic [rpa_pkg::CNT_W-1:0]        idx;
		logic                             busy;
		logic                             done;
		logic                             err;
		logic                             req;
		logic [rpa_pkg::ADR_W-1:0]        addr;
		logic [rpa_pkg::BYTE_W-1:0]       mask;
		logic [rpa_pkg::BYTE_W-1:0]       val;
	} rpa_main_s;

	rpa_main_s s_q;
	rpa_main_s s_d;

	rpa_rmw_if rmw ();

	logic [rpa_pkg::ENT_W-1:0]  cur_ent;
	logic [rpa_pkg::ENT_W-1:0]  tgt_ent;
	logic [rpa_pkg::CNT_W-1:0]  cur_cnt;
	logic [rpa_pkg::CNT_W-1:0]  tgt_cnt;
	logic [rpa_pkg::DP_W-1:0]   cur_dp;
	logic [rpa_pkg::DP_W-1:0]   tgt_dp;
	logic                       idle;

	assign idle = (s_q.st == rpa_pkg::ST_IDLE);

	// profile storage; loads only accepted while idle
	rpa_store u_store (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_wr       (i_load_ent && idle),
		.i_wr_prof  (i_load_prof),
		.i_wr_idx   (i_load_idx),
		.i_wr_ent   (i_load_data),
		.i_wr_cnt   (i_load_cnt && idle),
		.i_cnt      (i_load_count),
		.i_dp       (i_load_dpath),
		.i_cur      (s_q.cur),
		.i_tgt      (s_q.tgt),
		.i_idx      (s_q.idx[rpa_pkg::IDX_W-1:0]),
		.o_cur_ent  (cur_ent),
		.o_tgt_ent  (tgt_ent),
		.o_cur_cnt  (cur_cnt),
		.o_tgt_cnt  (tgt_cnt),
		.o_cur_dp   (cur_dp),
		.o_tgt_dp   (tgt_dp)
	);

	// bus master doing one read-modify-write per request
	rpa_master u_master (
		.i_core_clk       (i_core_clk),
		.i_nrst           (i_nrst),
		.rmw              (rmw.mst),
		.i_bus_grant      (i_bus_grant),
		.o_rc_address     (o_rc_address),
		.o_rc_read        (o_rc_read),
		.o_rc_write       (o_rc_write),
		.o_rc_writedata   (o_rc_writedata),
		.i_rc_readdata    (i_rc_readdata),
		.i_rc_waitrequest (i_rc_waitrequest)
	);

	// switch sequencer: check, scan entries, apply differing ones
	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			rpa_pkg::ST_IDLE:
			begin
				// any of the eight profile numbers may be selected
				if (i_sel_valid)
				begin
					s_d.tgt  = i_sel_prof;
					s_d.idx  = rpa_pkg::RST_IDX;
					s_d.busy = 1'b1;
					s_d.err  = 1'b0;
					s_d.st   = rpa_pkg::ST_CHECK;
				end
			end
			rpa_pkg::ST_CHECK:
			begin
				if (i_fractional_pll_core_mode)
				begin
					s_d.err = 1'b1;
					s_d.st  = rpa_pkg::ST_DONE;
				end
				else if (cur_dp != tgt_dp && !i_dpath_reconfig_en)
				begin
					s_d.err = 1'b1;
					s_d.st  = rpa_pkg::ST_DONE;
				end
				else if (cur_cnt != tgt_cnt)
				begin
					s_d.err = 1'b1;
					s_d.st  = rpa_pkg::ST_DONE;
				end
				else
					s_d.st = rpa_pkg::ST_SCAN;
			end
			rpa_pkg::ST_SCAN:
			begin
				if (s_q.idx == tgt_cnt)
					s_d.st = rpa_pkg::ST_DONE;
				else if (cur_ent[rpa_pkg::ADR_HI:rpa_pkg::ADR_LO] !=
					tgt_ent[rpa_pkg::ADR_HI:rpa_pkg::ADR_LO])
				begin
					s_d.err = 1'b1;
					s_d.st  = rpa_pkg::ST_DONE;
				end
				else if (cur_ent == tgt_ent)
					s_d.idx = s_q.idx + 5'h01; // identical entry skipped
				else
				begin
					// bridge, analog and logic entries alike
					s_d.addr = tgt_ent[rpa_pkg::ADR_HI:rpa_pkg::ADR_LO];
					s_d.mask = tgt_ent[rpa_pkg::MSK_HI:rpa_pkg::MSK_LO];
					s_d.val  = tgt_ent[rpa_pkg::VAL_HI:rpa_pkg::VAL_LO];
					s_d.req  = 1'b1;
					s_d.st   = rpa_pkg::ST_RMW;
				end
			end
			rpa_pkg::ST_RMW:
			begin
				// next entry only after this write was accepted
				if (rmw.ack)
				begin
					s_d.req = 1'b0;
					s_d.idx = s_q.idx + 5'h01;
					s_d.st  = rpa_pkg::ST_SCAN;
				end
			end
			rpa_pkg::ST_DONE:
			begin
				// active profile moves with done, only after a clean pass
				if (!s_q.err)
					s_d.cur = s_q.tgt;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.st   = rpa_pkg::ST_IDLE;
			end
			default:
			begin
				s_d.st   = rpa_pkg::ST_IDLE;
				s_d.busy = 1'b0;
				s_d.req  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s_q.st   <= rpa_pkg::ST_IDLE;
			s_q.cur  <= rpa_pkg::RST_PROF;
			s_q.tgt  <= rpa_pkg::RST_PROF;
			s_q.idx  <= rpa_pkg::RST_IDX;
			s_q.busy <= 1'b0;
			s_q.done <= 1'b0;
			s_q.err  <= 1'b0;
			s_q.req  <= 1'b0;
			s_q.addr <= '0;
			s_q.mask <= '0;
			s_q.val  <= '0;
		end
		else
			s_q <= s_d;
	end

	// request to the master and status outputs from flops
	assign rmw.req       = s_q.req;
	assign rmw.addr      = s_q.addr;
	assign rmw.mask      = s_q.mask;
	assign rmw.val       = s_q.val;
	assign o_bus_req     = s_q.busy;
	assign o_busy        = s_q.busy;
	assign o_done        = s_q.done;
	assign o_error       = s_q.err;
	assign o_active_prof = s_q.cur;
endmodule

// [verilog/rpa_master.sv]
// module: masked read-modify-write master on the reconfiguration bus
`timescale 1ns/1ns
module rpa_master (
	// clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_nrst,
	// request from the sequencer
	rpa_rmw_if.mst                             rmw,
	// config bus grant
	input  wire logic                          i_bus_grant,
	// reconfiguration bus
	output logic      [rpa_pkg::ADR_W-1:0]     o_rc_address,
	output logic                               o_rc_read,
	output logic                               o_rc_write,
	output logic      [rpa_pkg::BUS_W-1:0]     o_rc_writedata,
	input  wire logic [rpa_pkg::BUS_W-1:0]     i_rc_readdata,
	input  wire logic                          i_rc_waitrequest
);
	typedef struct packed {
		rpa_pkg::rpa_mst_e                st;
		logic [rpa_pkg::ADR_W-1:0]        addr;
		logic                             rd;
		logic                             wr;
		logic [rpa_pkg::BUS_W-1:0]        wdata;
		logic                             ack;
	} rpa_mst_s;

	rpa_mst_s m_q;
	rpa_mst_s m_d;
	logic [rpa_pkg::BYTE_W-1:0] merged;

	// next state of the read-modify-write sequence
	always_comb
	begin
		m_d     = m_q;
		m_d.ack = 1'b0;
		// old bits kept outside the mask, new bits inside it
		merged  = (i_rc_readdata[rpa_pkg::BYTE_W-1:0] & ~rmw.mask) |
			(rmw.val & rmw.mask);
		case (m_q.st)
			rpa_pkg::MS_IDLE:
			begin
				if (rmw.req && i_bus_grant)
				begin
					m_d.addr = rmw.addr;
					m_d.rd   = 1'b1;
					m_d.st   = rpa_pkg::MS_READ;
				end
			end
			rpa_pkg::MS_READ:
			begin
				// address and read held while stalled
				if (!i_rc_waitrequest)
				begin
					m_d.rd    = 1'b0;
					m_d.wr    = 1'b1;
					m_d.wdata = {i_rc_readdata[rpa_pkg::BUS_W-1:
						rpa_pkg::BYTE_W], merged};
					m_d.st    = rpa_pkg::MS_WRITE;
				end
			end
			rpa_pkg::MS_WRITE:
			begin
				if (!i_rc_waitrequest)
				begin
					m_d.wr  = 1'b0;
					m_d.ack = 1'b1;
					m_d.st  = rpa_pkg::MS_ACK;
				end
			end
			rpa_pkg::MS_ACK:
				m_d.st = rpa_pkg::MS_IDLE; // lets the request drop
			default:
			begin
				m_d.st = rpa_pkg::MS_IDLE;
				m_d.rd = 1'b0;
				m_d.wr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			m_q.st    <= rpa_pkg::MS_IDLE;
			m_q.addr  <= '0;
			m_q.rd    <= 1'b0;
			m_q.wr    <= 1'b0;
			m_q.wdata <= '0;
			m_q.ack   <= 1'b0;
		end
		else
			m_q <= m_d;
	end

	// bus outputs straight from flops
	assign o_rc_address   = m_q.addr;
	assign o_rc_read      = m_q.rd;
	assign o_rc_write     = m_q.wr;
	assign o_rc_writedata = m_q.wdata;
	assign rmw.ack        = m_q.ack;
endmodule

// [verilog/rpa_pkg.sv]
// package: shared widths, field positions, reset values and state codes
package rpa_pkg;
	// profile entry layout
	localparam int ENT_W     = 27;
	localparam int ADR_HI    = 26;
	localparam int ADR_LO    = 16;
	localparam int MSK_HI    = 15;
	localparam int MSK_LO    = 8;
	localparam int VAL_HI    = 7;
	localparam int VAL_LO    = 0;
	localparam int ADR_W     = ADR_HI - ADR_LO + 1;
	localparam int BYTE_W    = 8;
	// storage geometry
	localparam int NPROF     = 8;
	localparam int PROF_W    = 3;
	localparam int NENT      = 16;
	localparam int IDX_W     = 4;
	localparam int CNT_W     = 5;
	localparam int SLOT_W    = PROF_W + IDX_W;
	localparam int NSLOT     = NPROF * NENT;
	localparam int DP_W      = 2;
	localparam int BUS_W     = 32;
	// values after reset
	localparam logic [PROF_W-1:0] RST_PROF = 3'h0;
	localparam logic [CNT_W-1:0]  RST_IDX  = 5'h00;
	localparam logic [CNT_W-1:0]  RST_CNT  = 5'h00;
	localparam logic [DP_W-1:0]   RST_DP   = 2'h0;
	localparam logic [ENT_W-1:0]  RST_ENT  = 27'h0000000;

	// applier sequencing states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CHECK = 5'h02,
		ST_SCAN  = 5'h04,
		ST_RMW   = 5'h08,
		ST_DONE  = 5'h10
	} rpa_main_e;

	// bus master states
	typedef enum logic [3:0] {
		MS_IDLE  = 4'h1,
		MS_READ  = 4'h2,
		MS_WRITE = 4'h4,
		MS_ACK   = 4'h8
	} rpa_mst_e;
endpackage

// [verilog/rpa_rmw_if.sv]
// interface: one masked read-modify-write request and its completion
`timescale 1ns/1ns
interface rpa_rmw_if;
	logic                     req;
	logic [rpa_pkg::ADR_W-1:0]  addr;
	logic [rpa_pkg::BYTE_W-1:0] mask;
	logic [rpa_pkg::BYTE_W-1:0] val;
	logic                     ack;

	modport seq (output req, output addr, output mask, output val,
		input ack);
	modport mst (input req, input addr, input mask, input val,
		output ack);
endinterface

// [verilog/rpa_store.sv]
// module: flip-flop storage of eight profiles with counts and datapath
`timescale 1ns/1ns
module rpa_store (
	// clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_nrst,
	// load port
	input  wire logic                          i_wr,
	input  wire logic [rpa_pkg::PROF_W-1:0]    i_wr_prof,
	input  wire logic [rpa_pkg::IDX_W-1:0]     i_wr_idx,
	input  wire logic [rpa_pkg::ENT_W-1:0]     i_wr_ent,
	input  wire logic                          i_wr_cnt,
	input  wire logic [rpa_pkg::CNT_W-1:0]     i_cnt,
	input  wire logic [rpa_pkg::DP_W-1:0]      i_dp,
	// lookup of current and target profile
	input  wire logic [rpa_pkg::PROF_W-1:0]    i_cur,
	input  wire logic [rpa_pkg::PROF_W-1:0]    i_tgt,
	input  wire logic [rpa_pkg::IDX_W-1:0]     i_idx,
	output logic      [rpa_pkg::ENT_W-1:0]     o_cur_ent,
	output logic      [rpa_pkg::ENT_W-1:0]     o_tgt_ent,
	output logic      [rpa_pkg::CNT_W-1:0]     o_cur_cnt,
	output logic      [rpa_pkg::CNT_W-1:0]     o_tgt_cnt,
	output logic      [rpa_pkg::DP_W-1:0]      o_cur_dp,
	output logic      [rpa_pkg::DP_W-1:0]      o_tgt_dp
);
	typedef struct packed {
		logic [rpa_pkg::NSLOT-1:0][rpa_pkg::ENT_W-1:0] ent;
		logic [rpa_pkg::NPROF-1:0][rpa_pkg::CNT_W-1:0] cnt;
		logic [rpa_pkg::NPROF-1:0][rpa_pkg::DP_W-1:0]  dp;
	} rpa_store_s;

	rpa_store_s s_q;
	rpa_store_s s_d;

	// one packed word per entry, same layout whatever it was loaded from
	always_comb
	begin
		s_d = s_q;
		if (i_wr)
			s_d.ent[{i_wr_prof, i_wr_idx}] = i_wr_ent;
		if (i_wr_cnt)
		begin
			s_d.cnt[i_wr_prof] = i_cnt;
			s_d.dp[i_wr_prof]  = i_dp;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s_q.ent <= {rpa_pkg::NSLOT{rpa_pkg::RST_ENT}};
			s_q.cnt <= {rpa_pkg::NPROF{rpa_pkg::RST_CNT}};
			s_q.dp  <= {rpa_pkg::NPROF{rpa_pkg::RST_DP}};
		end
		else
			s_q <= s_d;
	end

	// lookups by profile and entry index
	assign o_cur_ent = s_q.ent[{i_cur, i_idx}];
	assign o_tgt_ent = s_q.ent[{i_tgt, i_idx}];
	assign o_cur_cnt = s_q.cnt[i_cur];
	assign o_tgt_cnt = s_q.cnt[i_tgt];
	assign o_cur_dp  = s_q.dp[i_cur];
	assign o_tgt_dp  = s_q.dp[i_tgt];
endmodule
